// ### eci_pkg.sv
// Package for the Ethernet controller interrupt logic: bit positions and reset values.
// Assumes a single 25 MHz device clock and an active-high power-on reset.
package eci_pkg;
  localparam int unsigned REG_W          = 16;
  localparam int unsigned CNT_W          = 8;
  localparam logic [7:0]  CNT_MAX        = 8'hff;
  localparam logic [7:0]  CNT_ZERO       = 8'h00;
  localparam logic [7:0]  CNT_ONE        = 8'h01;
  // Bit positions shared by flags and enables
  localparam int unsigned B_GLOBAL       = 15;
  localparam int unsigned B_MODEXP       = 14;
  localparam int unsigned B_HASH         = 13;
  localparam int unsigned B_CIPHER       = 12;
  localparam int unsigned B_LINK         = 11;
  localparam int unsigned B_PENDING      = 6;
  localparam int unsigned B_DMA          = 5;
  localparam int unsigned B_FIXED_ONE    = 4;
  localparam int unsigned B_TX_DONE      = 3;
  localparam int unsigned B_TX_ABORT     = 2;
  localparam int unsigned B_RX_ABORT     = 1;
  localparam int unsigned B_CNT_FULL     = 0;
  // Source bits; all writable in the enable register, all but the pending flag in the flag register
  localparam logic [15:0] SRC_MASK       = 16'h786f;
  // Flags software may clear (all sources but the pending flag)
  localparam logic [15:0] FLAG_CLR_MASK  = 16'h782f;
  localparam logic [15:0] ENABLE_RESET   = 16'h8010;
  localparam logic [15:0] FLAG_RESET     = 16'h0000;
  localparam logic [15:0] ENABLE_RW_MASK = 16'hf86f;
  typedef enum logic [1:0] {
    ECI_OP_NONE  = 2'b00,
    ECI_OP_WRITE = 2'b01,
    ECI_OP_SET   = 2'b11,
    ECI_OP_CLEAR = 2'b10
  } eci_op_t;
endpackage : eci_pkg

// ### eci_fall_det.sv
// Falling-edge detector bank: pulses when a busy/request level drops.
// Assumes its inputs come from logic on the same clock.
module eci_fall_det #(
  parameter int unsigned N = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [N-1:0] level,
  output logic      [N-1:0] fell
);
  logic [N-1:0] prev_q;
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          prev_q[i] <= 1'b0;
        end else begin
          prev_q[i] <= level[i];
        end
      end
      assign fell[i] = prev_q[i] & ~level[i];
    end
  endgenerate
endmodule : eci_fall_det

// ### eci_pkt_counter.sv
// Received-packet counter with saturation and receive-abort detection.
// Assumes accept and decrement strobes are one-cycle pulses on mclk.
module eci_pkt_counter
  import eci_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             pkt_accept,
  input  wire logic             buf_overrun,
  input  wire logic             pkt_decrement,
  output logic      [CNT_W-1:0] rx_packet_count,
  output logic                  drop_pulse,
  output logic                  full_pulse,
  output logic                  dec_pulse
);
  logic [CNT_W-1:0] count_q;
  logic             is_full;
  logic             do_inc;
  logic             do_dec;

  assign is_full    = (count_q == CNT_MAX);
  assign do_inc     = pkt_accept & ~buf_overrun & ~is_full;
  assign do_dec     = pkt_decrement & (count_q != CNT_ZERO);
  // Drop only for lack of room, never for a filter reject
  assign drop_pulse = pkt_accept & (buf_overrun | is_full);
  // Pulse on reaching the top value
  assign full_pulse = do_inc & ~do_dec & (count_q == CNT_MAX - CNT_ONE);
  assign dec_pulse  = do_dec;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_q <= CNT_ZERO;
    end else if (do_inc && !do_dec) begin
      count_q <= count_q + CNT_ONE;
    end else if (do_dec && !do_inc) begin
      count_q <= count_q - CNT_ONE;
    end
  end
  assign rx_packet_count = count_q;
endmodule : eci_pkt_counter

// ### eci_irq_top.sv
// Interrupt aggregation for a 10/100 Ethernet controller: flag and enable
// registers, packet counter and the active-low interrupt pin.
// Assumes event inputs are levels or pulses from logic on mclk.
module eci_irq_top
  import eci_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             rst,
  // Register port: op selects write, bit set or bit clear
  input  wire eci_pkg::eci_op_t flags_op,
  input  wire logic [REG_W-1:0] flags_wdata,
  input  wire eci_pkg::eci_op_t enables_op,
  input  wire logic [REG_W-1:0] enables_wdata,
  output logic      [REG_W-1:0] event_flags,
  output logic      [REG_W-1:0] event_enables,
  output logic                  irq_status,
  output logic      [CNT_W-1:0] rx_packet_count,
  output logic                  link_up,
  // Event sources
  input  wire logic             modexp_go,
  input  wire logic             cipher_go,
  input  wire logic             dma_go,
  input  wire logic             tx_request,
  input  wire logic             hash_done,
  input  wire logic             phy_link,
  input  wire logic             tx_aborted,
  input  wire logic             pkt_accept,
  input  wire logic             buf_overrun,
  input  wire logic             pkt_decrement,
  output logic                  irq_n
);
  import eci_pkg::*;

  logic [REG_W-1:0] flags_q;
  logic [REG_W-1:0] flags_d;
  logic [REG_W-1:0] en_q;
  logic [REG_W-1:0] set_ev;
  logic [REG_W-1:0] sw_clr;
  logic [3:0]       fell;
  logic             link_q;
  logic [CNT_W-1:0] count;
  logic             drop_pulse;
  logic             full_pulse;
  logic             dec_pulse;
  logic             pending;
  logic             cause;

  eci_fall_det #(.N(4)) u_fall (
    .mclk  (mclk),
    .rst   (rst),
    .level ({modexp_go, cipher_go, dma_go, tx_request}),
    .fell  (fell)
  );

  eci_pkt_counter u_cnt (
    .mclk            (mclk),
    .rst             (rst),
    .pkt_accept      (pkt_accept),
    .buf_overrun     (buf_overrun),
    .pkt_decrement   (pkt_decrement),
    .rx_packet_count (count),
    .drop_pulse      (drop_pulse),
    .full_pulse      (full_pulse),
    .dec_pulse       (dec_pulse)
  );

  // Link state tracker for change detection
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      link_q <= 1'b0;
    end else begin
      link_q <= phy_link;
    end
  end

  // Hardware set events, independent of enables
  always_comb begin
    set_ev              = '0;
    set_ev[B_MODEXP]    = fell[3];
    set_ev[B_HASH]      = hash_done;
    set_ev[B_CIPHER]    = fell[2];
    set_ev[B_LINK]      = link_q ^ phy_link;
    set_ev[B_DMA]       = fell[1];
    set_ev[B_TX_DONE]   = fell[0];
    set_ev[B_TX_ABORT]  = tx_aborted;
    set_ev[B_RX_ABORT]  = drop_pulse;
    set_ev[B_CNT_FULL]  = full_pulse;
  end

  // Software clear mask per operation; bit ops avoid losing fresh events
  always_comb begin
    sw_clr = '0;
    if (flags_op == ECI_OP_CLEAR) begin
      sw_clr = flags_wdata & FLAG_CLR_MASK;
    end else if (flags_op == ECI_OP_WRITE) begin
      sw_clr = ~flags_wdata & FLAG_CLR_MASK;
    end
  end

  // Hardware set wins over any clear in the same cycle
  always_comb begin
    flags_d = flags_q & ~sw_clr;
    if (flags_op == ECI_OP_SET || flags_op == ECI_OP_WRITE) begin
      flags_d = flags_d | (flags_wdata & FLAG_CLR_MASK);
    end
    if (dec_pulse) begin
      flags_d[B_CNT_FULL] = 1'b0;
    end
    flags_d = flags_d | set_ev;
    flags_d[B_PENDING] = 1'b0;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flags_q <= FLAG_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Pending flag mirrors the counter, read-only
  assign pending = (count != CNT_ZERO);

  // Enable register; fixed bit always one, reserved bits zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      en_q <= ENABLE_RESET;
    end else if (enables_op == ECI_OP_WRITE) begin
      en_q <= (enables_wdata & ENABLE_RW_MASK) | ENABLE_RESET & ~ENABLE_RW_MASK;
    end else if (enables_op == ECI_OP_SET) begin
      en_q <= en_q | (enables_wdata & ENABLE_RW_MASK);
    end else if (enables_op == ECI_OP_CLEAR) begin
      en_q <= en_q & ~(enables_wdata & ENABLE_RW_MASK);
    end
  end

  // Any enabled flag is a cause
  always_comb begin
    cause = |(flags_d & en_q & SRC_MASK);
    if (pending && en_q[B_PENDING]) begin
      cause = 1'b1;
    end
  end

  // Registered outputs; pin gated by global enable
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_status <= 1'b0;
      irq_n      <= 1'b1;
    end else begin
      irq_status <= cause;
      irq_n      <= ~(cause & en_q[B_GLOBAL]);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      event_flags     <= FLAG_RESET;
      event_enables   <= ENABLE_RESET;
      rx_packet_count <= CNT_ZERO;
      link_up         <= 1'b0;
    end else begin
      event_flags             <= flags_d;
      event_flags[B_PENDING]  <= pending;
      event_enables           <= en_q;
      rx_packet_count         <= count;
      link_up                 <= phy_link;
    end
  end
endmodule : eci_irq_top

// ### eci_irq_checker.sv
// Checker for eci_irq_top: pin, status, counter and fixed-bit relations.
// Assumes it is bound to the top module and sees only its ports.
module eci_irq_checker
  import eci_pkg::*;
(
  input wire logic             mclk,
  input wire logic             rst,
  input wire logic [REG_W-1:0] event_flags,
  input wire logic [REG_W-1:0] event_enables,
  input wire logic             irq_status,
  input wire logic [CNT_W-1:0] rx_packet_count,
  input wire logic             link_up,
  input wire logic             irq_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence seq_link_flip;
    $changed(link_up);
  endsequence
  sequence seq_link_flag;
    ##[0:2] event_flags[B_LINK];
  endsequence
  a_pin_off_high: assert property (!event_enables[B_GLOBAL] && !$past(event_enables[B_GLOBAL])
    |-> irq_n) else $error("pin low with global off");
  a_pin_follows_status: assert property (event_enables[B_GLOBAL] && $past(event_enables[B_GLOBAL])
    |-> irq_n == !irq_status) else $error("pin differs from status");
  a_irq_needs_global: assert property (!irq_n
    |-> event_enables[B_GLOBAL] || $past(event_enables[B_GLOBAL])) else $error("pin ungated");
  a_status_has_cause: assert property (irq_status |-> (|(event_flags & event_enables & SRC_MASK))
    || (|($past(event_flags) & $past(event_enables) & SRC_MASK))) else $error("no cause");
  a_fixed_bits: assert property (event_enables[B_FIXED_ONE] && event_enables[10:7] == 4'h0
    && event_flags[15] == 1'b0 && event_flags[10:7] == 4'h0) else $error("fixed bits");
  a_pending_count: assert property (event_flags[B_PENDING] == (rx_packet_count != CNT_ZERO))
    else $error("pending flag differs from count");
  a_count_step: assert property ($changed(rx_packet_count) |-> rx_packet_count ==
    $past(rx_packet_count) + CNT_ONE || rx_packet_count == $past(rx_packet_count) - CNT_ONE)
    else $error("count jumped");
  a_full_sets: assert property (rx_packet_count == CNT_MAX && $past(rx_packet_count) != CNT_MAX
    |-> ##[0:1] event_flags[B_CNT_FULL]) else $error("full flag missing");
  a_full_clears: assert property ($fell(rx_packet_count == CNT_MAX)
    |-> ##[0:1] !event_flags[B_CNT_FULL]) else $error("full flag stuck");
  a_link_flag: assert property (seq_link_flip |-> seq_link_flag)
    else $error("link change flag missing");
endmodule : eci_irq_checker

bind eci_irq_top eci_irq_checker chk_u (.mclk(mclk), .rst(rst), .event_flags(event_flags),
  .event_enables(event_enables), .irq_status(irq_status), .rx_packet_count(rx_packet_count),
  .link_up(link_up), .irq_n(irq_n));

// ### eci_host_model.sv
// Host controller model: register operations held for one cycle each.
// Assumes the bench calls its tasks; it drives on the falling edge.
module eci_host_model
  import eci_pkg::*;
(
  input  wire logic             mclk,
  output eci_pkg::eci_op_t      flags_op,
  output logic      [REG_W-1:0] flags_wdata,
  output eci_pkg::eci_op_t      enables_op,
  output logic      [REG_W-1:0] enables_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    flags_op = ECI_OP_NONE;
    enables_op = ECI_OP_NONE;
    flags_wdata = '0;
    enables_wdata = '0;
  end
  task automatic reg_op(input logic sel_en, input eci_op_t op, input logic [REG_W-1:0] d);
    @(negedge mclk);
    if (sel_en) begin
      enables_op = op;
      enables_wdata = d;
    end else begin
      flags_op = op;
      flags_wdata = d;
    end
    @(negedge mclk);
    flags_op = ECI_OP_NONE;
    enables_op = ECI_OP_NONE;
    // Released data lines do not keep their last value
    flags_wdata = ~flags_wdata;
    enables_wdata = ~enables_wdata;
  endtask : reg_op
  // Bit clear, so events landing meanwhile are not lost
  task automatic ack(input logic [REG_W-1:0] m);
    reg_op(1'b0, ECI_OP_CLEAR, m);
  endtask : ack
  // Called once pending packets are drained; sets the global and pending-packet enables
  task automatic arm_wake;
    reg_op(1'b1, ECI_OP_SET, 16'h8040);
  endtask : arm_wake
endmodule : eci_host_model

// ### tb_eci_irq_top.sv
// Self-checking bench for eci_irq_top with random event mixes.
// Assumes the host model and the bound checker are compiled with it.
module tb_eci_irq_top
  import eci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int POS [7] = '{B_MODEXP, B_CIPHER, B_DMA, B_TX_DONE, B_HASH, B_TX_ABORT, B_LINK};
  logic             mclk, rst, acc, ovr, dec, irq_status, link_up, irq_n;
  logic [6:0]       ev, m;
  eci_op_t          f_op, e_op;
  logic [REG_W-1:0] f_wd, e_wd, flags, enables, en;
  logic [CNT_W-1:0] cnt;
  int               n_fail, check_count, seed;
  eci_host_model host_u (.mclk(mclk), .flags_op(f_op), .flags_wdata(f_wd),
    .enables_op(e_op), .enables_wdata(e_wd));
  eci_irq_top dut_u (.mclk(mclk), .rst(rst), .flags_op(f_op), .flags_wdata(f_wd),
    .enables_op(e_op), .enables_wdata(e_wd), .event_flags(flags), .event_enables(enables),
    .irq_status(irq_status), .rx_packet_count(cnt), .link_up(link_up), .modexp_go(ev[0]),
    .cipher_go(ev[1]), .dma_go(ev[2]), .tx_request(ev[3]), .hash_done(ev[4]),
    .phy_link(ev[6]), .tx_aborted(ev[5]), .pkt_accept(acc), .buf_overrun(ovr),
    .pkt_decrement(dec), .irq_n(irq_n));
  function automatic logic [REG_W-1:0] ev2f(input logic [6:0] v);
    ev2f = '0;
    for (int i = 0; i < 7; i++) if (v[i]) ev2f[POS[i]] = 1'b1;
  endfunction : ev2f
  task automatic chk(input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Go bits rise then fall, pulses last one cycle, link toggles once
  task automatic fire(input logic [6:0] v);
    @(negedge mclk) ev = ev ^ v;
    @(negedge mclk) ev = ev ^ (v & 7'h3f);
  endtask : fire
  task automatic pkt(input logic a, input logic o, input logic d);
    @(negedge mclk) {acc, ovr, dec} = {a, o, d};
    @(negedge mclk) {acc, ovr, dec} = 3'b000;
  endtask : pkt
  task automatic w3;
    repeat (3) @(negedge mclk);
  endtask : w3
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    test_done;
  end
  initial begin
    seed = 36087;
    {rst, ev, acc, ovr, dec, n_fail, check_count} = {1'b1, 10'h0, 64'h0};
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    chk(enables, ENABLE_RESET);
    chk({15'h0, irq_n}, 16'h0001);
    host_u.reg_op(1'b1, ECI_OP_WRITE, 16'h0000);
    w3;
    chk(enables, 16'h0010);
    $display("reset and access test done");
    for (int k = 0; k < 24; k++) begin
      en = $random(seed);
      m = $random(seed);
      if (k < 2) {en, m} = {k ? 16'h786f : 16'h8000, 7'h7f};
      host_u.reg_op(1'b1, ECI_OP_WRITE, en);
      host_u.ack(16'hffff);
      fire(m);
      w3;
      chk(flags, ev2f(m));
      chk(enables, (en & ENABLE_RW_MASK) | 16'h0010);
      chk({15'h0, irq_n}, {15'h0, !(en[B_GLOBAL] && |(ev2f(m) & en & SRC_MASK))});
      chk({15'h0, irq_status}, {15'h0, |(ev2f(m) & en & SRC_MASK)});
      chk({15'h0, link_up}, {15'h0, ev[6]});
    end
    $display("random event test done");
    host_u.reg_op(1'b1, ECI_OP_WRITE, 16'h8008);
    host_u.ack(16'hffff);
    fire(7'h08);
    w3;
    chk({15'h0, irq_n}, 16'h0000);
    host_u.reg_op(1'b1, ECI_OP_CLEAR, 16'h8000);
    w3;
    chk({15'h0, irq_n}, 16'h0001);
    host_u.reg_op(1'b1, ECI_OP_SET, 16'h8000);
    w3;
    chk({15'h0, irq_n}, 16'h0000);
    host_u.ack(16'h0008);
    w3;
    chk({15'h0, irq_n}, 16'h0001);
    host_u.arm_wake;
    pkt(1'b1, 1'b0, 1'b0);
    w3;
    chk({8'h0, cnt}, 16'h0001);
    chk({15'h0, irq_n}, 16'h0000);
    host_u.reg_op(1'b0, ECI_OP_WRITE, 16'h0000);
    w3;
    chk(flags, 16'h0040);
    pkt(1'b0, 1'b0, 1'b1);
    w3;
    chk(flags, 16'h0000);
    pkt(1'b1, 1'b1, 1'b0);
    w3;
    chk(flags, 16'h0002);
    host_u.reg_op(1'b0, ECI_OP_SET, 16'hffff);
    w3;
    chk(flags, 16'h782f);
    chk({15'h0, irq_n}, 16'h0000);
    host_u.ack(16'hffff);
    repeat (255) pkt(1'b1, 1'b0, 1'b0);
    w3;
    chk(flags, 16'h0041);
    pkt(1'b1, 1'b0, 1'b0);
    w3;
    chk({8'h0, cnt}, {8'h0, CNT_MAX});
    chk(flags, 16'h0043);
    pkt(1'b0, 1'b0, 1'b1);
    w3;
    chk(flags, 16'h0042);
    $display("packet counter test done");
    test_done;
  end
endmodule : tb_eci_irq_top
